/* hw/wcs_map.vh */
// Register offsets, field positions, codes and timing constants
`ifndef WCS_MAP_VH
`define WCS_MAP_VH

// Avalon byte offsets
`define WCS_REG_CTRL       7'h00
`define WCS_REG_STATUS     7'h04
`define WCS_REG_COMPLETION 7'h08
`define WCS_REG_SLAVE_STAT 7'h0c
`define WCS_REG_DEF_RESP   7'h10
`define WCS_REG_MODEM      7'h14
`define WCS_REG_XMIT       7'h18
`define WCS_REG_DATA       7'h1c
`define WCS_REG_BLK_LEN    7'h20
`define WCS_REG_BLK_BASE   7'h24
`define WCS_BLK_BASE_W     5'd9
`define WCS_BLK_WORDS      17

// Field positions
`define WCS_CTRL_START     0
`define WCS_ST_BUSY        0
`define WCS_ST_DONE        1
`define WCS_ST_ERROR       2
`define WCS_ST_SESS_VALID  3
`define WCS_ST_SESS_MULTI  4
`define WCS_ST_STAT_STORED 5

// Data block word indexes (index 0 is the command number)
`define WCS_IX_CMD         0
`define WCS_IX_ID0         1
`define WCS_IX_MODE        5
`define WCS_IX_SLV_TYPE    6
`define WCS_IX_SLV_ADDR    7
`define WCS_IX_COUNT       8
`define WCS_IX_MST_TYPE    9
`define WCS_IX_STAT_TYPE   11
`define WCS_IX_STAT_ADDR   12
`define WCS_IX_RESP        13
`define WCS_IX_BCAST       14
`define WCS_IX_MODEM       15
`define WCS_IX_XMIT        16

// Block length limits and transfer limit
`define WCS_LEN_MIN        5'd11
`define WCS_LEN_MAX        5'd17
`define WCS_MAX_BYTES      17'd1000

// Codes
`define WCS_CMD_XWRITE     16'h1bbe
`define WCS_MODE_SINGLE    16'h0000
`define WCS_MODE_MULTI     16'h0001
`define WCS_ID_NULL        64'h0000000000000000
`define WCS_ID_BCAST       64'hffffffffffffffff
`define WCS_TYPE_R         16'h0008
`define WCS_TYPE_AI        16'h000a
`define WCS_TYPE_AQ        16'h000c
`define WCS_TYPE_I         16'h0046
`define WCS_FR_SESSION     16'h5a01
`define WCS_FR_WRITE       16'h5a02
`define WCS_OK             16'h0001
`define WCS_ERR_LEN        16'h0002
`define WCS_ERR_ID_MODE    16'h0003
`define WCS_ERR_SIZE       16'h0004
`define WCS_ERR_TIMEOUT    16'h0005
`define WCS_ERR_CMD        16'h0006

// Timing
`define WCS_CLK_NS         10
`define WCS_MS_NS          1000000
`define WCS_MS_CYCLES      (`WCS_MS_NS / `WCS_CLK_NS)
`define WCS_DEF_RESP_MS    16'd500
`define WCS_DEF_MODEM_MS   16'd0
`define WCS_DEF_XMIT_MS    16'd0
`define WCS_FIFO_WIDTH     16
`define WCS_FIFO_DEPTH     16
`endif

/* hw/wcs_fifo.v */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module wcs_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             i_clock,
	input  wire             i_rst,
	input  wire [WIDTH-1:0] i_in_data,
	input  wire             i_in_valid,
	output wire             o_in_ready,
	output wire [WIDTH-1:0] o_out_data,
	output wire             o_out_valid,
	input  wire             i_out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      fill;
	wire            push;
	wire            pop;

	assign o_in_ready  = (fill != DEPTH[AW:0]);
	assign o_out_valid = (fill != {(AW+1){1'b0}});
	assign o_out_data  = mem[rd_ptr];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always @(posedge i_clock) begin
		if (push)
			mem[wr_ptr] <= i_in_data;
	end

	always @(posedge i_clock) begin
		if (i_rst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			fill   <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop)
				fill <= fill + 1'b1;
			else if (pop && !push)
				fill <= fill - 1'b1;
		end
	end
endmodule // wcs_fifo

/* hw/wcs_sequencer.v */
// Fast remote write command sequencer with Avalon-MM register slave
`timescale 1ns/1ns
`include "wcs_map.vh"

// Behaviour
// R1: Ensure a suitable session exists, set one up if absent, then send write.
// R2: Transfer count elements, counted in units of the local memory access mode.
// R3: Zero-fill data where local and slave memory types differ.
// R4: All-FFh identifier allowed only with multi-session; writes every slave.
// R5: Requester never pairs the all-00h identifier with multi-session.
// R6: Session type word 0 means single-session, 1 means multi-session.
// R7: Single opens with one slave, multi with all; data goes to identified slave.
// R8: Session type plus identifier decide if current session is adequate.
// R9: One write command carries at most 1000 bytes.
// R10: Accept block lengths of 11 mandatory words plus up to 6 optional.
// R11: Parameters beyond the block length count as not programmed.
// R12: Store slave status word at optional location; skip if absent or zero.
// R13: Response timeout override in ms, else default response timer.
// R14: Wait broadcast delay after setup or broadcast; override or default timer.
// R15: Modem turnaround override in ms replaces configured value this command.
// R16: Transmission delay override in ms, else configured value, extends waits; code adds it to the response wait only.
// R17: On success write one into the completion status location.
// R18: Millisecond timers use a shared divided tick, restarted at each wait.
module wcs_sequencer #(
	parameter MS_CYCLES = `WCS_MS_CYCLES
) (
	input  wire        I_CLOCK,
	input  wire        I_RST,
	input  wire [6:0]  I_ADDRESS,
	input  wire        I_READ,
	input  wire        I_WRITE,
	input  wire [31:0] I_WRITEDATA,
	output reg  [31:0] O_READDATA,
	output reg         O_WAITREQUEST,
	output reg  [15:0] O_TX_DATA,
	output reg         O_TX_VALID,
	output reg         O_TX_LAST,
	input  wire        I_TX_READY,
	input  wire [15:0] I_RX_DATA,
	input  wire        I_RX_VALID
);
	localparam S_IDLE  = 4'd0;
	localparam S_CHECK = 4'd1;
	localparam S_TURN  = 4'd2;
	localparam S_SEND  = 4'd3;
	localparam S_WAIT  = 4'd4;
	localparam S_DONE  = 4'd5;

	reg  [3:0]  state;
	reg  [15:0] blk [0:`WCS_BLK_WORDS-1];
	reg  [4:0]  blk_len;
	reg  [15:0] def_resp_ms;
	reg  [15:0] modem_cfg_ms;
	reg  [15:0] xmit_cfg_ms;
	reg  [15:0] completion;
	reg  [15:0] slave_stat;
	reg         done;
	reg         error;
	reg         stat_stored;
	reg         sess_valid;
	reg         sess_multi;
	reg  [63:0] sess_id;
	reg         phase_write;
	reg  [9:0]  tx_idx;
	reg  [16:0] tmr_ms;
	reg  [16:0] tick_cnt;
	reg         expect_rx;

	wire        req;
	wire        acc_wr;
	wire        fifo_in_ready;
	wire [15:0] fifo_data;
	wire        fifo_valid;
	wire        fifo_pop;
	wire        tick;
	wire [63:0] slave_id;
	wire        id_bcast;
	wire        id_null;
	wire        mode_multi;
	wire        mode_ok;
	wire        bit_mode;
	wire        word_mode;
	wire [16:0] count_w;
	wire [16:0] bytes;
	wire [16:0] valid_bits;
	wire [9:0]  n_words;
	wire        sess_ok;
	wire        has_stat;
	wire        has_resp;
	wire        has_bcast;
	wire        has_modem;
	wire        has_xmit;
	wire [16:0] resp_ms;
	wire [16:0] bcast_ms;
	wire [16:0] modem_ms;
	wire [16:0] xmit_ms;
	wire [9:0]  hdr_words;
	wire [9:0]  data_idx;
	wire [15:0] data_mask;
	wire        in_data;
	wire [15:0] frame_word;
	wire        frame_last;
	wire        frame_stall;

	// Register access is answered one cycle after the request is seen; a data write waits until the FIFO has room
	assign req    = I_READ || I_WRITE;
	assign acc_wr = I_WRITE && !O_WAITREQUEST;

	wcs_fifo #(
		.WIDTH (`WCS_FIFO_WIDTH),
		.DEPTH (`WCS_FIFO_DEPTH),
		.AW    (4)
	) u_fifo (
		.i_clock     (I_CLOCK),
		.i_rst       (I_RST),
		.i_in_data   (I_WRITEDATA[15:0]),
		.i_in_valid  (acc_wr && I_ADDRESS == `WCS_REG_DATA),
		.o_in_ready  (fifo_in_ready),
		.o_out_data  (fifo_data),
		.o_out_valid (fifo_valid),
		.i_out_ready (fifo_pop)
	);

	assign slave_id   = {blk[`WCS_IX_ID0], blk[`WCS_IX_ID0+1],
	                     blk[`WCS_IX_ID0+2], blk[`WCS_IX_ID0+3]};
	assign id_bcast   = (slave_id == `WCS_ID_BCAST);
	assign id_null    = (slave_id == `WCS_ID_NULL);
	assign mode_multi = (blk[`WCS_IX_MODE] == `WCS_MODE_MULTI); // [R6]
	assign mode_ok    = (blk[`WCS_IX_MODE] == `WCS_MODE_SINGLE) ||
	                    mode_multi; // [R6]

	// Units follow the local memory access mode
	assign bit_mode  = (blk[`WCS_IX_MST_TYPE] == `WCS_TYPE_I);
	assign word_mode = (blk[`WCS_IX_MST_TYPE] == `WCS_TYPE_R) ||
	                   (blk[`WCS_IX_MST_TYPE] == `WCS_TYPE_AI) ||
	                   (blk[`WCS_IX_MST_TYPE] == `WCS_TYPE_AQ);
	assign count_w   = {1'b0, blk[`WCS_IX_COUNT]};
	assign bytes     = bit_mode ? ((count_w + 17'd7) >> 3) :
	                   word_mode ? {count_w[15:0], 1'b0} : count_w; // [R2]
	assign valid_bits = bit_mode ? count_w : {bytes[13:0], 3'b000};
	assign n_words   = bytes[10:1] + {9'd0, bytes[0]};

	// Adequate session: same kind, and for single the same slave
	assign sess_ok = sess_valid && (sess_multi == mode_multi) &&
	                 (mode_multi || sess_id == slave_id); // [R8]

	// Optional words count only inside the block length
	assign has_stat  = (blk_len > `WCS_IX_STAT_ADDR) &&
	                   (blk[`WCS_IX_STAT_TYPE] != 16'h0000 ||
	                    blk[`WCS_IX_STAT_ADDR] != 16'h0000); // [R11] [R12]
	assign has_resp  = (blk_len > `WCS_IX_RESP) &&
	                   (blk[`WCS_IX_RESP] != 16'h0000); // [R11]
	assign has_bcast = (blk_len > `WCS_IX_BCAST) &&
	                   (blk[`WCS_IX_BCAST] != 16'h0000); // [R11]
	assign has_modem = (blk_len > `WCS_IX_MODEM); // [R11]
	assign has_xmit  = (blk_len > `WCS_IX_XMIT); // [R11]
	assign xmit_ms   = {1'b0, has_xmit ? blk[`WCS_IX_XMIT] :
	                   xmit_cfg_ms}; // [R16]
	assign resp_ms   = {1'b0, has_resp ? blk[`WCS_IX_RESP] :
	                   def_resp_ms} + xmit_ms; // [R13] [R16]
	assign bcast_ms  = {1'b0, has_bcast ? blk[`WCS_IX_BCAST] :
	                   def_resp_ms}; // [R14]
	assign modem_ms  = {1'b0, has_modem ? blk[`WCS_IX_MODEM] :
	                   modem_cfg_ms}; // [R15]

	// Frame: header, four identifier words, then mode or write fields
	assign hdr_words = phase_write ? 10'd8 : 10'd6;
	assign in_data   = phase_write && (tx_idx >= hdr_words);
	assign data_idx  = tx_idx - hdr_words;

	genvar b;
	generate
		for (b = 0; b < 16; b = b + 1) begin : g_mask
			assign data_mask[b] = ({3'b000, data_idx, 4'h0} +
			                       b) < valid_bits; // [R3]
		end
	endgenerate

	reg [15:0] hdr_word;
	always @* begin
		hdr_word = 16'h0000;
		case (tx_idx[3:0])
		4'd0: hdr_word = phase_write ? `WCS_FR_WRITE : `WCS_FR_SESSION;
		4'd1: hdr_word = (!phase_write && mode_multi) ? 16'hffff :
		                 slave_id[63:48]; // [R7]
		4'd2: hdr_word = (!phase_write && mode_multi) ? 16'hffff :
		                 slave_id[47:32];
		4'd3: hdr_word = (!phase_write && mode_multi) ? 16'hffff :
		                 slave_id[31:16];
		4'd4: hdr_word = (!phase_write && mode_multi) ? 16'hffff :
		                 slave_id[15:0];
		4'd5: hdr_word = phase_write ? blk[`WCS_IX_SLV_TYPE] :
		                 blk[`WCS_IX_MODE];
		4'd6: hdr_word = blk[`WCS_IX_SLV_ADDR];
		4'd7: hdr_word = {6'd0, n_words};
		default: hdr_word = 16'h0000;
		endcase
	end

	assign frame_word  = in_data ? (fifo_data & data_mask) : hdr_word; // [R3]
	assign frame_stall = in_data && !fifo_valid;
	assign frame_last  = phase_write ? (tx_idx == hdr_words + n_words - 10'd1)
	                                 : (tx_idx == hdr_words - 10'd1);
	assign fifo_pop    = (state == S_SEND) && in_data && fifo_valid &&
	                     (!O_TX_VALID || I_TX_READY) && !O_TX_LAST;

	assign tick = (tick_cnt == MS_CYCLES - 1); // [R18]

	// Bus slave
	always @(posedge I_CLOCK) begin
		if (I_RST) begin
			O_WAITREQUEST <= 1'b1;
			O_READDATA    <= 32'h00000000;
		end else if (req && O_WAITREQUEST &&
		             !(I_WRITE && I_ADDRESS == `WCS_REG_DATA &&
		               !fifo_in_ready)) begin
			O_WAITREQUEST <= 1'b0;
			O_READDATA    <= 32'h00000000;
			if (I_ADDRESS == `WCS_REG_STATUS)
				O_READDATA[5:0] <= {stat_stored, sess_multi, sess_valid,
				                    error, done, state != S_IDLE};
			else if (I_ADDRESS == `WCS_REG_COMPLETION)
				O_READDATA[15:0] <= completion;
			else if (I_ADDRESS == `WCS_REG_SLAVE_STAT)
				O_READDATA[15:0] <= slave_stat;
			else if (I_ADDRESS == `WCS_REG_DEF_RESP)
				O_READDATA[15:0] <= def_resp_ms;
			else if (I_ADDRESS == `WCS_REG_MODEM)
				O_READDATA[15:0] <= modem_cfg_ms;
			else if (I_ADDRESS == `WCS_REG_XMIT)
				O_READDATA[15:0] <= xmit_cfg_ms;
			else if (I_ADDRESS == `WCS_REG_BLK_LEN)
				O_READDATA[4:0] <= blk_len;
			else if (I_ADDRESS >= `WCS_REG_BLK_BASE &&
			         I_ADDRESS[6:2] < `WCS_BLK_BASE_W + `WCS_BLK_WORDS)
				O_READDATA[15:0] <= blk[I_ADDRESS[6:2] - `WCS_BLK_BASE_W];
		end else begin
			O_WAITREQUEST <= 1'b1;
		end
	end

	// Configuration and parameter block; frozen while busy
	always @(posedge I_CLOCK) begin
		if (I_RST) begin
			def_resp_ms  <= `WCS_DEF_RESP_MS;
			modem_cfg_ms <= `WCS_DEF_MODEM_MS;
			xmit_cfg_ms  <= `WCS_DEF_XMIT_MS;
			blk_len      <= 5'd0;
		end else if (acc_wr && state == S_IDLE) begin
			if (I_ADDRESS == `WCS_REG_DEF_RESP)
				def_resp_ms <= I_WRITEDATA[15:0];
			else if (I_ADDRESS == `WCS_REG_MODEM)
				modem_cfg_ms <= I_WRITEDATA[15:0];
			else if (I_ADDRESS == `WCS_REG_XMIT)
				xmit_cfg_ms <= I_WRITEDATA[15:0];
			else if (I_ADDRESS == `WCS_REG_BLK_LEN)
				blk_len <= I_WRITEDATA[4:0];
		end
	end

	always @(posedge I_CLOCK) begin
		if (acc_wr && state == S_IDLE && I_ADDRESS >= `WCS_REG_BLK_BASE &&
		    I_ADDRESS[6:2] < `WCS_BLK_BASE_W + `WCS_BLK_WORDS)
			blk[I_ADDRESS[6:2] - `WCS_BLK_BASE_W] <= I_WRITEDATA[15:0];
	end

	// Sequencer
	always @(posedge I_CLOCK) begin
		if (I_RST) begin
			state       <= S_IDLE;
			completion  <= 16'h0000;
			slave_stat  <= 16'h0000;
			done        <= 1'b0;
			error       <= 1'b0;
			stat_stored <= 1'b0;
			sess_valid  <= 1'b0;
			sess_multi  <= 1'b0;
			sess_id     <= 64'h0;
			phase_write <= 1'b0;
			tx_idx      <= 10'd0;
			tmr_ms      <= 17'd0;
			tick_cnt    <= 17'd0;
			expect_rx   <= 1'b0;
			O_TX_DATA   <= 16'h0000;
			O_TX_VALID  <= 1'b0;
			O_TX_LAST   <= 1'b0;
		end else begin
			tick_cnt <= tick ? 17'd0 : tick_cnt + 17'd1; // [R18]
			if (tick && tmr_ms != 17'd0)
				tmr_ms <= tmr_ms - 17'd1;
			if (O_TX_VALID && I_TX_READY) begin
				O_TX_VALID <= 1'b0;
				O_TX_LAST  <= 1'b0;
			end
			case (state)
			S_IDLE: begin
				if (acc_wr && I_ADDRESS == `WCS_REG_CTRL &&
				    I_WRITEDATA[`WCS_CTRL_START]) begin
					done        <= 1'b0;
					error       <= 1'b0;
					stat_stored <= 1'b0;
					state       <= S_CHECK;
				end
			end
			S_CHECK: begin
				if (blk_len < `WCS_LEN_MIN || blk_len > `WCS_LEN_MAX) begin
					completion <= `WCS_ERR_LEN; // [R10]
					error      <= 1'b1;
					state      <= S_DONE;
				end else if (blk[`WCS_IX_CMD] != `WCS_CMD_XWRITE) begin
					completion <= `WCS_ERR_CMD;
					error      <= 1'b1;
					state      <= S_DONE;
				end else if (!mode_ok || (id_bcast && !mode_multi) ||
				             (id_null && mode_multi)) begin
					completion <= `WCS_ERR_ID_MODE; // [R4] [R5]
					error      <= 1'b1;
					state      <= S_DONE;
				end else if (bytes > `WCS_MAX_BYTES) begin
					completion <= `WCS_ERR_SIZE; // [R9]
					error      <= 1'b1;
					state      <= S_DONE;
				end else begin
					phase_write <= sess_ok; // [R1] [R8]
					tmr_ms      <= modem_ms; // [R15]
					tick_cnt    <= 17'd0;
					state       <= S_TURN;
				end
			end
			S_TURN: begin
				if (tmr_ms == 17'd0) begin
					tx_idx <= 10'd0;
					state  <= S_SEND;
				end
			end
			S_SEND: begin
				if ((!O_TX_VALID || I_TX_READY) && !O_TX_LAST &&
				    !frame_stall) begin
					O_TX_DATA  <= frame_word;
					O_TX_VALID <= 1'b1;
					O_TX_LAST  <= frame_last;
					tx_idx     <= tx_idx + 10'd1;
				end
				if (O_TX_VALID && I_TX_READY && O_TX_LAST) begin
					// Slaves never answer broadcasts
					if ((phase_write && id_bcast) ||
					    (!phase_write && mode_multi)) begin
						tmr_ms    <= bcast_ms; // [R14]
						expect_rx <= 1'b0;
					end else begin
						tmr_ms    <= resp_ms; // [R13]
						expect_rx <= 1'b1;
					end
					tick_cnt <= 17'd0; // [R18]
					state    <= S_WAIT;
				end
			end
			S_WAIT: begin
				if (expect_rx && I_RX_VALID) begin
					if (phase_write) begin
						completion <= `WCS_OK; // [R17]
						if (has_stat) begin
							slave_stat  <= I_RX_DATA; // [R12]
							stat_stored <= 1'b1;
						end
						state <= S_DONE;
					end else begin
						sess_valid  <= 1'b1; // [R7]
						sess_multi  <= 1'b0;
						sess_id     <= slave_id;
						phase_write <= 1'b1;
						tmr_ms      <= modem_ms; // [R15]
						tick_cnt    <= 17'd0;
						state       <= S_TURN;
					end
				end else if (tmr_ms == 17'd0) begin
					if (expect_rx) begin
						completion <= `WCS_ERR_TIMEOUT;
						error      <= 1'b1;
						sess_valid <= 1'b0;
						state      <= S_DONE;
					end else if (phase_write) begin
						completion <= `WCS_OK; // [R4] [R17]
						state      <= S_DONE;
					end else begin
						sess_valid  <= 1'b1; // [R7]
						sess_multi  <= 1'b1;
						sess_id     <= `WCS_ID_BCAST;
						phase_write <= 1'b1;
						tmr_ms      <= modem_ms;
						tick_cnt    <= 17'd0;
						state       <= S_TURN;
					end
				end
			end
			S_DONE: begin
				done  <= 1'b1;
				state <= S_IDLE;
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule // wcs_sequencer

/* test/wcs_sequencer_sva.sv */
// Port checker for the write command sequencer
`timescale 1ns/1ns
`include "wcs_map.vh"
module wcs_sequencer_sva (
	input wire        I_CLOCK,
	input wire        I_RST,
	input wire        I_READ,
	input wire        I_WRITE,
	input wire        O_WAITREQUEST,
	input wire [15:0] O_TX_DATA,
	input wire        O_TX_VALID,
	input wire        O_TX_LAST,
	input wire        I_TX_READY
);
	reg  [9:0]  idx;
	reg  [15:0] hdr;
	reg  [15:0] nw;
	wire        take = O_TX_VALID && I_TX_READY;
	wire        ses = take && hdr == `WCS_FR_SESSION && idx != 10'h000;
	wire        wrf = take && hdr == `WCS_FR_WRITE && idx != 10'h000;
	// Word position inside the current frame
	always @(posedge I_CLOCK) begin
		if (I_RST)
			idx <= 10'h000;
		else if (take)
			idx <= O_TX_LAST ? 10'h000 : idx + 10'h001;
		if (take && idx == 10'h000)
			hdr <= O_TX_DATA;
		if (take && idx == 10'h007)
			nw <= O_TX_DATA;
	end
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_RST);
	AST_WAIT_ONE: assert property (!O_WAITREQUEST |=> O_WAITREQUEST)
		else $error("waitrequest low for more than one cycle");
	AST_WAIT_CAUSE: assert property ($fell(O_WAITREQUEST) |->
		$past(I_READ || I_WRITE)) else $error("answer without request");
	AST_TX_HOLD: assert property (O_TX_VALID && !I_TX_READY |=>
		O_TX_VALID && $stable(O_TX_DATA) && $stable(O_TX_LAST))
		else $error("link word changed before taken");
	AST_FRAME_HDR: assert property (take && idx == 10'h000 |->
		O_TX_DATA == `WCS_FR_SESSION || O_TX_DATA == `WCS_FR_WRITE)
		else $error("frame starts with unknown header");
	AST_SESS_LEN: assert property (ses |-> O_TX_LAST == (idx == 10'h005))
		else $error("session frame length wrong");
	AST_SESS_MODE: assert property (ses && idx == 10'h005 |->
		O_TX_DATA <= 16'h0001) else $error("session type word out of range");
	AST_WR_SIZE: assert property (wrf && idx == 10'h007 |->
		O_TX_DATA <= 16'd500) else $error("write frame above 1000 bytes");
	AST_WR_LEN: assert property (wrf |-> O_TX_LAST ==
		((idx == 10'h007 && O_TX_DATA == 16'h0000) ||
		 (idx > 10'h007 && {6'h00, idx} == nw + 16'h0007)))
		else $error("write frame length differs from word count");
endmodule // wcs_sequencer_sva
bind wcs_sequencer wcs_sequencer_sva wcs_sequencer_sva_inst (
	.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_READ(I_READ), .I_WRITE(I_WRITE),
	.O_WAITREQUEST(O_WAITREQUEST), .O_TX_DATA(O_TX_DATA),
	.O_TX_VALID(O_TX_VALID), .O_TX_LAST(O_TX_LAST), .I_TX_READY(I_TX_READY));

/* test/wcs_slave_model.sv */
// Behavioural slave station at the far end of the link
`timescale 1ns/1ns
module wcs_slave_model (
	input  wire        i_clock,
	input  wire        i_rst,
	input  wire [15:0] i_tx_data,
	input  wire        i_tx_valid,
	input  wire        i_tx_last,
	output reg         o_tx_ready,
	output reg  [15:0] o_rx_data,
	output reg         o_rx_valid,
	input  wire [15:0] i_delay,
	input  wire [15:0] i_status,
	input  wire        i_mute,
	input  wire        i_stall
);
	reg [3:0]  idx;
	reg [15:0] hdr;
	reg [15:0] cnt;
	reg [7:0]  lf;
	reg        bc;
	reg        pend;
	wire       take = i_tx_valid && o_tx_ready;
	always @(posedge i_clock) begin
		lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
		o_tx_ready <= !i_stall || lf[0];
		o_rx_valid <= 1'b0;
		// Reply lines carry a moving pattern outside the reply cycle
		o_rx_data <= ~o_rx_data;
		if (i_rst) begin
			idx <= 4'h0;
			pend <= 1'b0;
			lf <= 8'h1d;
			o_tx_ready <= 1'b0;
			o_rx_data <= 16'h5555;
		end else if (take) begin
			idx <= i_tx_last ? 4'h0 : (idx == 4'hf ? idx : idx + 4'h1);
			if (idx == 4'h0)
				hdr <= i_tx_data;
			if (idx >= 4'h1 && idx <= 4'h4)
				bc <= (idx == 4'h1 || bc) && i_tx_data == 16'hffff;
			// Only single setup and addressed writes are answered
			if (i_tx_last && !i_mute) begin
				pend <= hdr == 16'h5a01 ? i_tx_data == 16'h0000 : !bc;
				cnt <= i_delay;
			end
		end else if (pend) begin
			cnt <= cnt - 16'h0001;
			if (cnt == 16'h0000) begin
				pend <= 1'b0;
				o_rx_valid <= 1'b1;
				o_rx_data <= i_status;
			end
		end
	end
endmodule // wcs_slave_model

/* test/wcs_sequencer_test.sv */
// Self-checking bench for the write command sequencer
`timescale 1ns/1ns
`include "wcs_map.vh"
module wcs_sequencer_test;
	reg          clk, rst, rd, wr, mute, stall;
	reg  [6:0]   adr;
	reg  [31:0]  wd, rdat, seed;
	reg  [15:0]  dly, sts;
	wire [31:0]  o_rd;
	wire [15:0]  txd, rxd;
	wire         wreq, txv, txl, txr, rxv;
	logic [15:0] blk [0:16];
	logic [15:0] dq [$];
	logic [15:0] txq [$];
	integer      err_count, total_checks, cyc, tlast, k;
	wcs_sequencer #(.MS_CYCLES(10)) wcs_sequencer_inst (.I_CLOCK(clk),
		.I_RST(rst), .I_ADDRESS(adr), .I_READ(rd), .I_WRITE(wr),
		.I_WRITEDATA(wd), .O_READDATA(o_rd), .O_WAITREQUEST(wreq),
		.O_TX_DATA(txd), .O_TX_VALID(txv), .O_TX_LAST(txl),
		.I_TX_READY(txr), .I_RX_DATA(rxd), .I_RX_VALID(rxv));
	wcs_slave_model wcs_slave_model_inst (.i_clock(clk), .i_rst(rst),
		.i_tx_data(txd), .i_tx_valid(txv), .i_tx_last(txl),
		.o_tx_ready(txr), .o_rx_data(rxd), .o_rx_valid(rxv),
		.i_delay(dly), .i_status(sts), .i_mute(mute), .i_stall(stall));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (txv === 1'b1 && txr === 1'b1) begin
			txq.push_back(txd);
			tlast <= cyc;
		end
	end
	function automatic logic [15:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction
	function automatic integer nbytes(input [15:0] t, input [15:0] c);
		if (t == `WCS_TYPE_I)
			return (c + 7) / 8;
		if (t == `WCS_TYPE_R || t == `WCS_TYPE_AI || t == `WCS_TYPE_AQ)
			return 2 * c;
		return c;
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		total_checks = total_checks + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task bus(input w, input [6:0] a, input [31:0] d);
		integer n;
		n = 0;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk);
			n = n + 1;
		end while (wreq !== 1'b0 && n < 5000);
		rdat = o_rd;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 5000)
			chk(n, 0);
	endtask
	task rreg(input [6:0] a, input [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	task setup(input [15:0] id, md, ty, cnt, st);
		integer i;
		blk[0] = `WCS_CMD_XWRITE;
		for (i = 1; i < 5; i++)
			blk[i] = id;
		blk[5] = md;
		blk[6] = `WCS_TYPE_R;
		blk[7] = rnd();
		blk[8] = cnt;
		blk[9] = ty;
		blk[10] = 16'h0001;
		blk[11] = st;
		blk[12] = st;
		for (i = 13; i < 17; i++)
			blk[i] = 16'h0000;
		dq = {};
		for (i = 0; i < (nbytes(ty, cnt) + 1) / 2; i++)
			dq.push_back(rnd());
		dly <= rnd() & 16'h001f;
		sts <= rnd();
	endtask
	// Load block, start, feed data behind the start, wait for idle
	task go(input [4:0] len);
		integer i, n;
		txq = {};
		for (i = 0; i < 17; i++)
			bus(1'b1, `WCS_REG_BLK_BASE + 7'(4 * i), {16'h0000, blk[i]});
		bus(1'b1, `WCS_REG_BLK_LEN, {27'h0, len});
		bus(1'b1, `WCS_REG_CTRL, 32'h1);
		for (i = 0; i < dq.size(); i++)
			bus(1'b1, `WCS_REG_DATA, {16'h0000, dq[i]});
		n = 0;
		do begin
			bus(1'b0, `WCS_REG_STATUS, 32'h0);
			n = n + 1;
		end while (rdat[0] !== 1'b0 && n < 3000);
		if (rdat[0] !== 1'b0)
			chk(rdat, 32'h0);
	endtask
	task frames(input sess);
		logic [15:0] e [$];
		logic [15:0] w;
		integer      nb, nw, i, j, bits;
		e = {};
		if (sess) begin
			e.push_back(`WCS_FR_SESSION);
			for (i = 1; i < 5; i++)
				e.push_back(blk[5] == 16'h1 ? 16'hffff : blk[i]);
			e.push_back(blk[5]);
		end
		nb = nbytes(blk[9], blk[8]);
		nw = (nb + 1) / 2;
		bits = blk[9] == `WCS_TYPE_I ? blk[8] : nb * 8;
		e.push_back(`WCS_FR_WRITE);
		for (i = 1; i < 8; i++)
			e.push_back(i == 5 ? blk[6] : (i == 6 ? blk[7] : blk[i]));
		e[e.size() - 1] = nw[15:0];
		for (i = 0; i < nw; i++) begin
			w = dq[i];
			for (j = 0; j < 16; j++)
				if (i * 16 + j >= bits)
					w[j] = 1'b0;
			e.push_back(w);
		end
		chk(txq.size(), e.size());
		for (i = 0; i < e.size() && i < txq.size(); i++)
			chk(txq[i], e[i]);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		{rd, wr, mute, stall, adr, wd, cyc, tlast} = 0;
		{err_count, total_checks, dly, sts} = 0;
		rst = 1'b1;
		seed = 32'h1056;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rreg(`WCS_REG_DEF_RESP, 32'd500);
		rreg(`WCS_REG_MODEM, 32'h0);
		rreg(`WCS_REG_XMIT, 32'h0);
		rreg(7'h7c, 32'h0);
		$display("test defaults done");
		setup(16'h0000, 16'h0, `WCS_TYPE_I, 16'd10, 16'h0008);
		go(5'd17);
		frames(1'b1);
		rreg(`WCS_REG_COMPLETION, 32'h1);
		rreg(`WCS_REG_SLAVE_STAT, {16'h0000, sts});
		$display("test single null id done");
		stall <= 1'b1;
		setup(16'h0000, 16'h0, `WCS_TYPE_R, 16'd20, 16'h0008);
		go(5'd11);
		frames(1'b0);
		rreg(`WCS_REG_STATUS, 32'h0000000a);
		$display("test reused session done");
		setup(16'hffff, 16'h1, `WCS_TYPE_AI, 16'd3, 16'h0008);
		blk[14] = 16'd20;
		go(5'd17);
		chk(cyc - tlast >= 195 && cyc - tlast <= 215, 1);
		frames(1'b1);
		rreg(`WCS_REG_COMPLETION, 32'h1);
		rreg(`WCS_REG_STATUS, 32'h0000001a);
		$display("test broadcast done");
		for (k = 0; k < 3; k++) begin
			setup(k == 2 ? 16'h0 : 16'h1234, k == 2 ? 16'h1 : 16'h0,
				`WCS_TYPE_R, k == 1 ? 16'd501 : 16'd1, 16'h0);
			dq = {};
			go(k == 0 ? 5'd10 : 5'd17);
			chk(txq.size(), 0);
			rreg(`WCS_REG_COMPLETION, k == 0 ? 2 : (k == 1 ? 4 : 3));
		end
		$display("test refusals done");
		mute <= 1'b1;
		setup(16'h4321, 16'h1, `WCS_TYPE_R, 16'd2, 16'h0);
		blk[13] = 16'd2;
		blk[16] = 16'd3;
		go(5'd17);
		rreg(`WCS_REG_COMPLETION, 32'h5);
		chk(cyc - tlast >= 40 && cyc - tlast <= 70, 1);
		$display("test timeout done");
		end_of_test;
	end
	// Hang guard, well beyond the longest expected run
	initial begin
		#900000;
		err_count = err_count + 1;
		end_of_test;
	end
endmodule // wcs_sequencer_test
